// File: event_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Three-flop input synchroniser; change accepted when stages two and three agree
module event_sync (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic din,
  output var  logic dout
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } sync_state_type;

  sync_state_type st_reg;
  sync_state_type st_next;

  // Shift chain and agreement filter
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.q = st_reg.s3;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.q;

endmodule // event_sync
`default_nettype wire

// File: rise_detect.sv
`timescale 1ns/1ns
`default_nettype none
// One-cycle pulse on each rising edge of an already synchronised level
module rise_detect (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic level,
  output var  logic pulse
);

  typedef struct packed {
    logic last;
  } rise_state_type;

  rise_state_type st_reg;
  rise_state_type st_next;

  // Remember previous level
  always_comb begin
    st_next      = st_reg;
    st_next.last = level;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pulse = level & ~st_reg.last;

endmodule // rise_detect
`default_nettype wire

// File: vme_event_source.sv
`timescale 1ns/1ns
`default_nettype none
module vme_event_source (
  input wire logic                       ref_clk,
  input wire logic                       rstn,
  input wire logic                       go,
  input wire vme_regs_pkg::hw_event_type pattern,
  output var vme_regs_pkg::hw_event_type ev
);
  import vme_regs_pkg::*;
  logic [2:0] hold_reg;
  // Event levels stand four cycles so the synchroniser sees them; post level is live
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hold_reg <= 3'h0;
      ev       <= '0;
    end else begin
      hold_reg     <= go ? 3'h4 : (hold_reg != 3'h0 ? hold_reg - 3'h1 : 3'h0);
      ev           <= (go || hold_reg > 3'h1) ? pattern : hw_event_type'({13'h0000, pattern.post_held});
    end
  end
endmodule // vme_event_source
`default_nettype wire

// File: vme_interface_status_and_slave_config.sv
`timescale 1ns/1ns
`default_nettype none
module vme_interface_status_and_slave_config (
  input  wire logic                       ref_clk,
  input  wire logic                       rstn,
  input  wire vme_regs_pkg::avmm_req_type avs_req,
  output var  vme_regs_pkg::avmm_rsp_type avs_rsp,
  input  wire vme_regs_pkg::hw_event_type hw_events,
  output var  vme_regs_pkg::vme_cfg_type  cfg,
  output var  logic                       irq
);
  import vme_regs_pkg::*;

  // Event index in the interrupt status register
  localparam int EV_BUS_ERR = 0;
  localparam int EV_DMA_BSY = 1;
  localparam int EV_DMA_ERR = 2;
  localparam int EV_LOC_ERR = 3;
  localparam int EV_VME_ERR = 4;
  localparam int EV_COUNT   = 5;

  typedef struct packed {
    logic [7:0]          amc;
    logic [7:0]          bus_err;
    logic [7:0]          dma_flags;
    logic [7:0]          ss0_c0;
    logic [7:0]          ss0_tim;
    logic [7:0]          ss1_c0;
    logic [7:0]          ss1_tim;
    logic [7:0]          rel;
    logic [EV_COUNT-1:0] irq_stat;
    logic [EV_COUNT-1:0] irq_mask;
    logic [31:0]         rdata;
    logic                ack;
    logic                stall;
    logic                irq;
    vme_cfg_type         cfg;
  } regs_state_type;

  regs_state_type st_reg;
  regs_state_type st_next;

  // Byte-lane merge of a write into an 8-bit register on lane 0
  function automatic logic [7:0] lane_write(input logic [7:0] old_v, input avmm_req_type rq);
    lane_write = rq.byteenable[0] ? rq.writedata[7:0] : old_v;
  endfunction

  // Write-one-to-clear with set winning over clear
  function automatic logic [7:0] w1c_set(input logic [7:0] old_v, input logic [7:0] set_v,
                                         input logic [7:0] clr_v);
    w1c_set = (old_v & ~clr_v) | set_v;
  endfunction

  // Synchronised external status pins
  logic [7:0] bus_err_lvl;
  logic [7:0] bus_err_pulse;
  logic [5:0] misc_lvl;
  logic [5:0] misc_raw;
  logic [5:0] misc_pulse;

  assign misc_raw = {hw_events.dma_start, hw_events.dma_local_err, hw_events.dma_vme_err,
                     hw_events.local_err, hw_events.vme_err, hw_events.post_held};

  // Bus error condition pins
  for (genvar g = 0; g < 8; g++) begin : g_berr
    event_sync u_sync (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .din     (hw_events.bus_err_set[g]),
      .dout    (bus_err_lvl[g])
    );
    rise_detect u_rise (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .level   (bus_err_lvl[g]),
      .pulse   (bus_err_pulse[g])
    );
  end

  // DMA and error condition pins
  for (genvar g = 0; g < 6; g++) begin : g_misc
    event_sync u_sync (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .din     (misc_raw[g]),
      .dout    (misc_lvl[g])
    );
    rise_detect u_rise (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .level   (misc_lvl[g]),
      .pulse   (misc_pulse[g])
    );
  end

  // Decoded event pulses and the live posting level
  logic       ev_dma_start;
  logic       ev_dma_lerr;
  logic       ev_dma_verr;
  logic       ev_loc_err;
  logic       ev_vme_err;
  logic       post_level;
  logic [7:0] dma_set;

  assign ev_dma_start = misc_pulse[5];
  assign ev_dma_lerr  = misc_pulse[4];
  assign ev_dma_verr  = misc_pulse[3];
  assign ev_loc_err   = misc_pulse[2];
  assign ev_vme_err   = misc_pulse[1];
  assign post_level   = misc_lvl[0];

  // Sticky DMA status set vector
  always_comb begin
    dma_set                = 8'h00;
    dma_set[DMA_BUSY_BIT]  = ev_dma_start;
    dma_set[DMA_LOCAL_BUS_ERROR_SIGNAL_BIT] = ev_dma_lerr;
    dma_set[DMA_VBERR_BIT] = ev_dma_verr;
    dma_set[LOC_BERR_BIT]  = ev_loc_err;
    dma_set[VME_BERR_BIT]  = ev_vme_err;
  end

  // Interrupt event vector
  logic [EV_COUNT-1:0] irq_set;
  assign irq_set = {ev_vme_err, ev_loc_err, ev_dma_lerr | ev_dma_verr, ev_dma_start,
                    |bus_err_pulse};

  // Bus access qualifiers; reads load on entry, writes commit on the acknowledge edge
  logic        wr_go;
  logic        rd_go;
  logic [7:0]  wlane;
  logic [7:0]  dma_view;
  logic [31:0] rd_mux;

  assign wr_go = avs_req.write & st_reg.ack;
  assign rd_go = avs_req.read & ~st_reg.ack;
  assign wlane = avs_req.byteenable[0] ? avs_req.writedata[7:0] : 8'h00;

  // Live view of the DMA status: sticky bits, fixed ones, live posting flag
  always_comb begin
    dma_view            = (st_reg.dma_flags & DMA_STICKY) | DMA_RSVD_ONES;
    dma_view[WPOST_BIT] = post_level;
  end

  // Read data selection
  always_comb begin
    case (avs_req.address)
      ADDR_AMC:      rd_mux = {24'h00_0000, st_reg.amc};
      ADDR_BUS_ERR:  rd_mux = {24'h00_0000, st_reg.bus_err};
      ADDR_DMA_STAT: rd_mux = {24'h00_0000, dma_view};
      ADDR_SS0_C0:   rd_mux = {24'h00_0000, st_reg.ss0_c0};
      ADDR_SS0_TIM:  rd_mux = {24'h00_0000, st_reg.ss0_tim};
      ADDR_SS1_C0:   rd_mux = {24'h00_0000, st_reg.ss1_c0};
      ADDR_SS1_TIM:  rd_mux = {24'h00_0000, st_reg.ss1_tim};
      ADDR_RELEASE:  rd_mux = {24'h00_0000, st_reg.rel};
      ADDR_IRQ_STAT: rd_mux = {27'h000_0000, st_reg.irq_stat};
      ADDR_IRQ_MASK: rd_mux = {27'h000_0000, st_reg.irq_mask};
      default:       rd_mux = UNMAPPED_DATA;
    endcase
  end

  // Next-state logic for registers, handshake and outputs
  always_comb begin
    logic [7:0] berr_clr;
    logic [7:0] dma_clr;
    logic [EV_COUNT-1:0] irq_clr;
    berr_clr = 8'h00;
    dma_clr  = 8'h00;
    irq_clr  = '0;
    st_next  = st_reg;
    st_next.ack = (avs_req.read | avs_req.write) & ~st_reg.ack;
    st_next.stall = ~st_next.ack;   // Waitrequest kept in its own flop
    if (rd_go) begin
      st_next.rdata = rd_mux;
    end
    if (wr_go) begin
      case (avs_req.address)
        ADDR_AMC:      st_next.amc      = lane_write(st_reg.amc, avs_req);
        ADDR_SS0_C0:   st_next.ss0_c0   = lane_write(st_reg.ss0_c0, avs_req);
        ADDR_SS0_TIM:  st_next.ss0_tim  = lane_write(st_reg.ss0_tim, avs_req);
        ADDR_SS1_C0:   st_next.ss1_c0   = lane_write(st_reg.ss1_c0, avs_req);
        ADDR_SS1_TIM:  st_next.ss1_tim  = lane_write(st_reg.ss1_tim, avs_req);
        ADDR_RELEASE:  st_next.rel      = lane_write(st_reg.rel, avs_req);
        ADDR_BUS_ERR:  berr_clr = wlane;
        ADDR_DMA_STAT: dma_clr  = wlane & DMA_STICKY;
        ADDR_IRQ_STAT: irq_clr  = wlane[EV_COUNT-1:0];
        ADDR_IRQ_MASK: st_next.irq_mask = wlane[EV_COUNT-1:0];
        default: begin
        end
      endcase
    end
    // Sticky flags: events set, only processor writes clear, set wins
    st_next.bus_err   = w1c_set(st_reg.bus_err, bus_err_pulse, berr_clr);
    st_next.dma_flags = w1c_set(st_reg.dma_flags, dma_set, dma_clr);
    st_next.irq_stat  = (st_reg.irq_stat & ~irq_clr) | irq_set;
    st_next.irq       = |(st_next.irq_stat & st_next.irq_mask);
    // Configuration fields out to the interface logic
    st_next.cfg.ss0_accel    = st_next.ss0_c0[SS_ACCEL_LSB +: 2];
    st_next.cfg.ss0_space    = st_next.ss0_c0[SS_SPACE_LSB +: 2];
    st_next.cfg.ss0_d32      = st_next.ss0_c0[SS_D32_BIT];
    st_next.cfg.ss0_super    = st_next.ss0_c0[SS_SUPER_BIT];
    st_next.cfg.ss0_timer    = st_next.ss0_c0[SS_MPOST_BIT +: 2];
    st_next.cfg.ss0_timing   = st_next.ss0_tim;
    st_next.cfg.ss1_accel    = st_next.ss1_c0[SS_ACCEL_LSB +: 2];
    st_next.cfg.ss1_space    = st_next.ss1_c0[SS_SPACE_LSB +: 2];
    st_next.cfg.ss1_d32      = st_next.ss1_c0[SS_D32_BIT];
    st_next.cfg.ss1_super    = st_next.ss1_c0[SS_SUPER_BIT];
    st_next.cfg.ss1_mpost    = st_next.ss1_c0[SS_MPOST_BIT];
    st_next.cfg.ss1_spost    = st_next.ss1_c0[SS_SPOST_BIT];
    st_next.cfg.ss1_timing   = st_next.ss1_tim;
    st_next.cfg.burst_len    = st_next.rel[REL_BURST_LSB +: 6];
    st_next.cfg.release_mode = st_next.rel[REL_MODE_LSB +: 2];
    st_next.cfg.am_code      = st_next.amc;
  end

  // State register; waitrequest stands high through reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg       <= '0;
      st_reg.stall <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops
  assign avs_rsp             = '{readdata: st_reg.rdata, waitrequest: st_reg.stall};
  assign cfg                 = st_reg.cfg;
  assign irq                 = st_reg.irq;

endmodule // vme_interface_status_and_slave_config
`default_nettype wire

// File: vme_interface_status_and_slave_config_tb.sv
`timescale 1ns/1ns
`default_nettype none
module vme_interface_status_and_slave_config_tb;
  import vme_regs_pkg::*;
  logic         ref_clk;
  logic         rstn;
  logic         go;
  logic         irq;
  logic [31:0]  q;
  avmm_req_type req;
  avmm_rsp_type rsp;
  hw_event_type pat;
  hw_event_type ev;
  hw_event_type p;
  vme_cfg_type  cfg;
  int           miscompares;
  int           checked;
  int           cycles;

  vme_interface_status_and_slave_config DUT (.ref_clk(ref_clk), .rstn(rstn), .avs_req(req), .avs_rsp(rsp),
    .hw_events(ev), .cfg(cfg), .irq(irq));
  vme_event_source far_end (.ref_clk(ref_clk), .rstn(rstn), .go(go), .pattern(pat), .ev(ev));

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Verdict and end of run
  task automatic final_report;
    $display("counts: checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic expect32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus transfer, held until waitrequest is sampled low; junk on upper lanes
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    req.address   <= a;
    req.read      <= ~w;
    req.write     <= w;
    req.writedata <= {24'hFF_FFFF, d};
    req.byteenable <= 4'hF;
    do @(posedge ref_clk); while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    expect32(q, exp);
  endtask

  // Drop the request and let cycles pass
  task automatic settle(input int n);
    req.read  <= 1'b0;
    req.write <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask

  // Far side raises the given events, then status has time to land
  task automatic fire(input hw_event_type e);
    pat <= e;
    go  <= 1'b1;
    settle(1);
    go  <= 1'b0;
    repeat (14) @(posedge ref_clk);
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      final_report;
    end
  end

  initial begin
    rstn = 1'b0;
    go = 1'b0;
    pat = '0;
    req = '0;
    miscompares = 0;
    checked = 0;
    cycles = 0;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    // Reset values of all words, one unmapped word last
    for (int i = 0; i < 11; i++) begin
      rd_chk(6'(4 * i), (i == 2) ? 32'h0000_0060 : 32'h0000_0000);
    end
    $display("test reset_values done");
    // Mandated setup written back to back, then read back
    wr(ADDR_SS0_C0, 8'h16);
    wr(ADDR_SS1_C0, 8'h12);
    wr(ADDR_SS0_TIM, 8'h00);
    wr(ADDR_SS1_TIM, 8'h00);
    wr(ADDR_RELEASE, 8'hC5);
    wr(ADDR_AMC, 8'h3D);
    wr(6'h28, 8'hFF);
    rd_chk(ADDR_SS0_C0, 32'h0000_0016);
    rd_chk(ADDR_SS1_C0, 32'h0000_0012);
    rd_chk(ADDR_SS0_TIM, 32'h0000_0000);
    rd_chk(ADDR_RELEASE, 32'h0000_00C5);
    rd_chk(6'h28, 32'h0000_0000);
    expect32({cfg.ss0_space, cfg.ss1_space, cfg.burst_len, cfg.release_mode, cfg.am_code},
      {SPACE_A24, SPACE_A32, 6'h05, 2'h3, 8'h3D});
    $display("test slave_config done");
    // Bus error flags outlive their causes and clear bit by bit
    fire(hw_event_type'(14'h2040));
    rd_chk(ADDR_BUS_ERR, 32'h0000_0081);
    fire('0);
    rd_chk(ADDR_BUS_ERR, 32'h0000_0081);
    wr(ADDR_BUS_ERR, 8'h01);
    rd_chk(ADDR_BUS_ERR, 32'h0000_0080);
    wr(ADDR_BUS_ERR, 8'h80);
    rd_chk(ADDR_BUS_ERR, 32'h0000_0000);
    $display("test bus_error done");
    // Each dma flag alone, write-post level held high
    for (int i = 0; i < 5; i++) begin
      p = hw_event_type'(14'h0001 | (14'h0001 << (5 - i)));
      fire(p);
      rd_chk(ADDR_DMA_STAT, 32'h0000_00E0 | (32'h0000_0001 << i));
      wr(ADDR_DMA_STAT, 8'h1F);
      rd_chk(ADDR_DMA_STAT, 32'h0000_00E0);
    end
    $display("test dma_status done");
    // Interrupt raised, masked and cleared
    wr(ADDR_IRQ_STAT, 8'hFF);
    wr(ADDR_IRQ_MASK, 8'h00);
    fire(hw_event_type'(14'h0004));
    expect32(irq, 1'b0);
    rd_chk(ADDR_IRQ_STAT, 32'h0000_0008);
    wr(ADDR_IRQ_STAT, 8'h08);
    settle(4);
    expect32(irq, 1'b0);
    wr(ADDR_IRQ_MASK, 8'h1F);
    fire(hw_event_type'(14'h0004));
    expect32(irq, 1'b1);
    wr(ADDR_IRQ_STAT, 8'hFF);
    settle(4);
    expect32(irq, 1'b0);
    $display("test interrupt done");
    final_report;
  end
endmodule // vme_interface_status_and_slave_config_tb

bind vme_interface_status_and_slave_config vme_regs_monitor mon (.ref_clk(ref_clk), .rstn(rstn),
  .avs_req(avs_req), .avs_rsp(avs_rsp), .hw_events(hw_events), .cfg(cfg), .irq(irq));
`default_nettype wire

// File: vme_regs_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module vme_regs_monitor (
  input wire logic                       ref_clk,
  input wire logic                       rstn,
  input wire vme_regs_pkg::avmm_req_type avs_req,
  input wire vme_regs_pkg::avmm_rsp_type avs_rsp,
  input wire vme_regs_pkg::hw_event_type hw_events,
  input wire vme_regs_pkg::vme_cfg_type  cfg,
  input wire logic                       irq
);
  import vme_regs_pkg::*;
  logic [7:0] cap_reg;
  default clocking mc @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Keep the data of the last accepted write
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cap_reg <= 8'h00;
    end else if (avs_req.write && !avs_rsp.waitrequest) begin
      cap_reg <= avs_req.writedata[7:0];
    end
  end
  // Accepted write and answered read
  sequence wr_to(logic [5:0] a);
    avs_req.write && !avs_rsp.waitrequest && avs_req.address == a;
  endsequence
  sequence rd_done;
    avs_req.read && !avs_rsp.waitrequest;
  endsequence
  one_wait_a: assert property ((avs_req.read || avs_req.write) && avs_rsp.waitrequest |=> !avs_rsp.waitrequest)
    else $error("request not answered after one wait cycle");
  ack_pulse_a: assert property (!avs_rsp.waitrequest |=> avs_rsp.waitrequest)
    else $error("waitrequest low for more than one cycle");
  rsvd_ones_a: assert property (rd_done ##0 avs_req.address == ADDR_DMA_STAT |-> avs_rsp.readdata[6:5] == 2'h3)
    else $error("reserved dma status bits not ones");
  upper_zero_a: assert property (rd_done |-> avs_rsp.readdata[31:8] == 24'h00_0000)
    else $error("upper read lanes not zero");
  unmapped_a: assert property (rd_done ##0 avs_req.address > ADDR_IRQ_MASK |-> avs_rsp.readdata == UNMAPPED_DATA)
    else $error("unmapped read not zero");
  release_cfg_a: assert property (wr_to(ADDR_RELEASE) |-> ##2 cfg.burst_len == cap_reg[5:0]
    && cfg.release_mode == cap_reg[7:6]) else $error("release control fields wrong");
  ss0_cfg_a: assert property (wr_to(ADDR_SS0_C0) |-> ##2 {cfg.ss0_timer, cfg.ss0_super, cfg.ss0_d32,
    cfg.ss0_space, cfg.ss0_accel} == cap_reg) else $error("slave select 0 fields wrong");
  ss1_cfg_a: assert property (wr_to(ADDR_SS1_C0) |-> ##2 {cfg.ss1_spost, cfg.ss1_mpost, cfg.ss1_super,
    cfg.ss1_d32, cfg.ss1_space, cfg.ss1_accel} == cap_reg) else $error("slave select 1 fields wrong");
  timing_cfg_a: assert property (wr_to(ADDR_SS1_TIM) |-> ##2 cfg.ss1_timing == cap_reg)
    else $error("slave select 1 timing wrong");
  timing0_cfg_a: assert property (wr_to(ADDR_SS0_TIM) |-> ##2 cfg.ss0_timing == cap_reg)
    else $error("slave select 0 timing wrong");
  am_code_a: assert property (wr_to(ADDR_AMC) |-> ##2 cfg.am_code == cap_reg)
    else $error("address modifier code wrong");
endmodule // vme_regs_monitor
`default_nettype wire

// File: vme_regs_pkg.sv
`default_nettype none
package vme_regs_pkg;

  // Register byte addresses on the Avalon-MM word bus
  localparam logic [5:0] ADDR_AMC      = 6'h00;
  localparam logic [5:0] ADDR_BUS_ERR  = 6'h04;
  localparam logic [5:0] ADDR_DMA_STAT = 6'h08;
  localparam logic [5:0] ADDR_SS0_C0   = 6'h0C;
  localparam logic [5:0] ADDR_SS0_TIM  = 6'h10;
  localparam logic [5:0] ADDR_SS1_C0   = 6'h14;
  localparam logic [5:0] ADDR_SS1_TIM  = 6'h18;
  localparam logic [5:0] ADDR_RELEASE  = 6'h1C;
  localparam logic [5:0] ADDR_IRQ_STAT = 6'h20;
  localparam logic [5:0] ADDR_IRQ_MASK = 6'h24;

  // DMA status field positions
  localparam int DMA_BUSY_BIT   = 0;
  localparam int DMA_LOCAL_BUS_ERROR_SIGNAL_BIT  = 1;
  localparam int DMA_VBERR_BIT  = 2;
  localparam int LOC_BERR_BIT   = 3;
  localparam int VME_BERR_BIT   = 4;
  localparam int WPOST_BIT      = 7;
  localparam logic [7:0] DMA_RSVD_ONES = 8'h60;
  localparam logic [7:0] DMA_STICKY    = 8'h1F;

  // Slave select control-0 fields
  localparam int SS_ACCEL_LSB  = 0;
  localparam int SS_SPACE_LSB  = 2;
  localparam int SS_D32_BIT    = 4;
  localparam int SS_SUPER_BIT  = 5;
  localparam int SS_MPOST_BIT  = 6;
  localparam int SS_SPOST_BIT  = 7;
  localparam logic [1:0] SPACE_A32 = 2'h0;
  localparam logic [1:0] SPACE_A24 = 2'h1;

  // Release control fields
  localparam int REL_BURST_LSB = 0;
  localparam int REL_MODE_LSB  = 6;

  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;

  // Read data for unmapped addresses
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // Avalon-MM request
  typedef struct packed {
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avmm_req_type;

  // Avalon-MM answer
  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } avmm_rsp_type;

  // Hardware event inputs
  typedef struct packed {
    logic [7:0] bus_err_set;
    logic       dma_start;
    logic       dma_local_err;
    logic       dma_vme_err;
    logic       local_err;
    logic       vme_err;
    logic       post_held;
  } hw_event_type;

  // Decoded configuration out to the interface logic
  typedef struct packed {
    logic [1:0] ss0_accel;
    logic [1:0] ss0_space;
    logic       ss0_d32;
    logic       ss0_super;
    logic [1:0] ss0_timer;
    logic [7:0] ss0_timing;
    logic [1:0] ss1_accel;
    logic [1:0] ss1_space;
    logic       ss1_d32;
    logic       ss1_super;
    logic       ss1_mpost;
    logic       ss1_spost;
    logic [7:0] ss1_timing;
    logic [5:0] burst_len;
    logic [1:0] release_mode;
    logic [7:0] am_code;
  } vme_cfg_type;

endpackage
`default_nettype wire
